// >>> design/pmcp_pkg.sv
package pmcp_pkg;
  // Character codes the parser reacts to
  localparam logic [6:0] CH_NUL = 7'h00;
  localparam logic [6:0] CH_BS = 7'h08;
  localparam logic [6:0] CH_LF = 7'h0A;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_DLE = 7'h10;
  localparam logic [6:0] CH_DC1 = 7'h11;
  localparam logic [6:0] CH_DC4 = 7'h14;
  localparam logic [6:0] CH_SUB = 7'h1A;
  localparam logic [6:0] CH_ESC = 7'h1B;
  localparam logic [6:0] CH_SP = 7'h20;
  localparam logic [6:0] CH_EXIT = 7'h21;
  localparam logic [6:0] CH_CLEAR = 7'h23;
  localparam logic [6:0] CH_CLOSE = 7'h24;
  localparam logic [6:0] CH_OPEN = 7'h25;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_POINT = 7'h2E;
  localparam logic [6:0] CH_D0 = 7'h30;
  localparam logic [6:0] CH_D1 = 7'h31;
  localparam logic [6:0] CH_D9 = 7'h39;
  localparam logic [6:0] CH_SEMI = 7'h3B;
  localparam logic [6:0] CH_RECALL = 7'h3F;
  localparam logic [6:0] CH_ALARM = 7'h41;
  localparam logic [6:0] CH_GO = 7'h47;
  localparam logic [6:0] CH_REMOTE = 7'h4C;
  localparam logic [6:0] CH_PROG = 7'h50;
  localparam logic [6:0] CH_TALK = 7'h54;
  localparam logic [6:0] CH_SEQ = 7'h58;
  localparam logic [6:0] CH_COMPUTE = 7'h5A;
  localparam logic [6:0] CH_LBR = 7'h5B;
  localparam logic [6:0] CH_RBR = 7'h5D;
  // Sizes, counts, program numbers and options
  localparam int SEQ_DEPTH = 128;
  localparam logic [7:0] SEQ_LEN_MAX = 8'h80;
  localparam logic [2:0] TRAILER_LEN = 3'h6;
  localparam logic [1:0] MAX_PROGS = 2'h3;
  localparam logic [3:0] LIMITS_PROG = 4'h6;
  localparam logic [3:0] TIME_PROG = 4'h9;
  localparam logic [3:0] OPT_REAL_TIME = 4'h1;
  // Register map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_PROGS = 8'h08;
  localparam logic [7:0] A_CONST = 8'h0C;
  localparam logic [7:0] A_START = 8'h10;
  localparam logic [7:0] A_INTVL = 8'h14;
  localparam logic [7:0] A_END = 8'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;

  typedef logic [19:0] pmcp_time_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_OPEN = 4'b0001, ST_DEFINE = 4'b0010,
    ST_LIST = 4'b0011, ST_RUN = 4'b0100, ST_WAIT = 4'b0101
  } pmcp_state_t;
  typedef enum logic [2:0] {
    ACT_COMPUTE = 3'b000, ACT_RECALL = 3'b001, ACT_CLEAR = 3'b010,
    ACT_ENTER = 3'b011, ACT_EXIT = 3'b100
  } pmcp_act_t;
  typedef struct packed {
    logic valid; pmcp_act_t act; logic neg; logic [2:0] dp;
    logic [27:0] mag;
  } pmcp_panel_t;
  typedef struct packed {
    logic psel; logic penable; logic pwrite; logic [7:0] paddr;
    logic [31:0] pwdata;
  } pmcp_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata; logic pready; logic pslverr;
  } pmcp_apb_rsp_t;
endpackage : pmcp_pkg

// >>> design/pmcp_parser.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module pmcp_parser import pmcp_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire pmcp_apb_req_t apb_req,
  output pmcp_apb_rsp_t apb_rsp,
  // Character stream from the terminal
  input wire logic rx_valid,
  input wire logic [6:0] rx_char,
  output logic rx_ready,
  // Character stream to the terminal
  output logic tx_valid,
  output logic [6:0] tx_char,
  input wire logic tx_ready,
  // Measurement front end and output formatter
  output logic fwd_valid,
  output logic [6:0] fwd_char,
  output pmcp_panel_t panel,
  output logic meas_go,
  output logic rt_load,
  input wire pmcp_time_t rtc_now,
  input wire logic msg_end,
  // Mode state
  output logic remote_mode_on,
  output logic print_talk_setting,
  output logic alarm_print_on,
  output logic alarm_filter,
  output logic processing_on,
  output logic [2:0][3:0] prog_list
);
  typedef struct packed {
    pmcp_state_t st; logic tx_v; logic [6:0] tx_ch;
    logic fwd_v; logic [6:0] fwd_ch; pmcp_panel_t pnl;
    logic go; logic rtl; logic dle; logic exp_prog; logic pfresh;
    logic letter_v; logic [6:0] letter; logic go_pend; logic engaged;
    logic seq_act; logic remote; logic talk; logic alarm; logic proc_on;
    logic [2:0][3:0] progs; logic [1:0] pcnt; logic [3:0] last_prog;
    logic [1:0] pidx; logic [3:0] opt; logic prev_ent;
    logic [27:0] cmag; logic cneg; logic [2:0] cdp; logic cdig; logic cpt;
    pmcp_time_t t_start; pmcp_time_t t_int; pmcp_time_t t_end;
    logic timed; logic [6:0] ptr; logic [7:0] len; logic [2:0] trl;
    logic en; logic [31:0] prdata; logic pslverr;
  } pmcp_regs_t;

  pmcp_regs_t s, next_s;
  logic [6:0] mem [SEQ_DEPTH];
  logic mem_we;
  logic [6:0] mem_wa, mem_wd, c, emit_ch, mem_q;
  logic take, par, emit_v, is_digit, late, early;
  logic [1:0] idx;

  assign rx_ready = !s.tx_v && s.trl == 3'h0 && s.en;
  assign take = rx_valid && rx_ready;
  assign mem_q = mem[s.ptr];
  assign c = (s.st == ST_RUN) ? mem_q : rx_char;
  assign is_digit = c >= CH_D0 && c <= CH_D9;
  assign late = s.timed && rtc_now > s.t_end;
  assign early = s.timed && rtc_now < s.t_start;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.pnl.valid = 1'b0;
    next_s.go = 1'b0;
    next_s.rtl = 1'b0;
    next_s.fwd_v = 1'b0;
    mem_we = 1'b0;
    mem_wa = s.len[6:0];
    mem_wd = c;
    emit_v = 1'b0;
    emit_ch = c;
    idx = s.pidx;
    par = 1'b0;
    if (s.tx_v && tx_ready) next_s.tx_v = 1'b0;
    if (msg_end && s.trl == 3'h0) next_s.trl = TRAILER_LEN;
    if (s.trl != 3'h0) begin
      if (!s.tx_v) begin
        emit_v = 1'b1;
        emit_ch = (s.trl == TRAILER_LEN) ? CH_CR :
                  (s.trl == 3'h5) ? CH_LF : CH_NUL;
        next_s.trl = s.trl - 3'h1;
      end
    end else if (take && (s.st == ST_RUN || s.st == ST_WAIT)) begin
      next_s.st = ST_IDLE;
      next_s.seq_act = 1'b0;
    end else if (s.st == ST_WAIT) begin
      if (!early) begin
        next_s.go = 1'b1;
        next_s.st = s.seq_act ? ST_RUN : ST_IDLE;
      end
    end else if (s.st == ST_RUN) begin
      if (!s.tx_v && s.en) begin
        par = 1'b1;
        next_s.ptr = (c == CH_CLOSE || {1'b0, s.ptr} + 8'h1 >= s.len)
                     ? 7'h0 : s.ptr + 7'h1;
      end
    end else if (take) begin
      unique case (s.st)
        ST_IDLE: par = 1'b1;
        ST_OPEN, ST_DEFINE: begin
          if (s.st == ST_OPEN && c == CH_SUB) begin
            emit_v = 1'b1;
            emit_ch = mem_q;
            next_s.ptr = 7'h1;
            next_s.st = (mem_q == CH_CLOSE) ? ST_IDLE : ST_LIST;
          end else if (c == CH_ESC) begin
            next_s.st = ST_IDLE;
          end else begin
            next_s.st = (c == CH_CLOSE) ? ST_IDLE : ST_DEFINE;
            // Store restarts only on a new definition, so listing keeps length
            if (s.st == ST_OPEN) begin
              mem_we = 1'b1;
              mem_wa = 7'h0;
              next_s.len = 8'h1;
            end else if (s.len < SEQ_LEN_MAX) begin
              mem_we = 1'b1;
              next_s.len = s.len + 8'h1;
            end
          end
        end
        ST_LIST: begin
          if (c == CH_SUB) begin
            emit_v = 1'b1;
            emit_ch = mem_q;
            next_s.ptr = s.ptr + 7'h1;
            if (mem_q == CH_CLOSE) next_s.st = ST_IDLE;
          end else if (c == CH_BS) begin
            emit_v = 1'b1;
            if (s.ptr != 7'h0) next_s.ptr = s.ptr - 7'h1;
          end else if (c == CH_ESC) begin
            next_s.st = ST_IDLE;
          end else if ({1'b0, s.ptr} < s.len) begin
            // Overwrite only: insertion would shift the whole store
            mem_we = 1'b1;
            mem_wa = s.ptr;
            next_s.ptr = s.ptr + 7'h1;
          end
        end
        default: next_s.st = ST_IDLE;
      endcase
    end

    if (par) begin
      next_s.exp_prog = s.exp_prog && c == CH_CLEAR;
      next_s.prev_ent = 1'b0;
      if (s.dle) begin
        emit_v = 1'b1;
        next_s.dle = 1'b0;
      end else if (c == CH_DLE) begin
        emit_v = 1'b1;
        next_s.dle = 1'b1;
      end else if (c >= CH_DC1 && c <= CH_DC4) begin
        emit_v = 1'b1;
      end else if (s.letter_v) begin
        next_s.letter_v = 1'b0;
        unique case (s.letter)
          CH_ALARM: next_s.alarm = c == CH_D1;
          CH_REMOTE: next_s.remote = c == CH_D1;
          CH_TALK: next_s.talk = c == CH_D0;
          default: begin
            next_s.engaged = c == CH_D1;
            if (c == CH_D0) begin
              next_s.st = ST_IDLE;
              next_s.seq_act = 1'b0;
            end
          end
        endcase
      end else if (s.exp_prog && is_digit) begin
        next_s.proc_on = 1'b1;
        next_s.exp_prog = 1'b1;
        next_s.last_prog = c[3:0];
        if (s.pcnt < MAX_PROGS) begin
          next_s.progs[s.pcnt] = c[3:0];
          next_s.pcnt = s.pcnt + 2'h1;
        end
      end else if (c == CH_PROG) begin
        next_s.exp_prog = 1'b1;
        next_s.pfresh = 1'b0;
        if (s.pfresh) begin
          next_s.progs = '0;
          next_s.pcnt = 2'h0;
        end
      end else if (c == CH_COMPUTE || c == CH_RECALL || c == CH_CLEAR) begin
        next_s.pnl.valid = 1'b1;
        next_s.pnl.act = (c == CH_COMPUTE) ? ACT_COMPUTE :
                         (c == CH_RECALL) ? ACT_RECALL : ACT_CLEAR;
      end else if (c == CH_EXIT) begin
        next_s.pnl.valid = 1'b1;
        next_s.pnl.act = ACT_EXIT;
        next_s.proc_on = 1'b0;
        next_s.progs = '0;
        next_s.pcnt = 2'h0;
        next_s.timed = 1'b0;
        next_s.cmag = 28'h0;
        next_s.cdig = 1'b0;
      end else if (c == CH_SEMI || c == CH_LBR || c == CH_RBR) begin
        next_s.pnl.valid = 1'b1;
        next_s.pnl.act = ACT_ENTER;
        next_s.pnl.mag = s.cmag;
        next_s.pnl.neg = s.cneg;
        next_s.pnl.dp = s.cdp;
        next_s.prev_ent = 1'b1;
        if (c == CH_LBR) idx = 2'h0;
        if (s.last_prog == TIME_PROG && s.cdig) begin
          unique case (idx)
            2'h0: next_s.opt = s.cmag[3:0];
            2'h1: next_s.t_start = s.cmag[19:0];
            2'h2: next_s.t_int = s.cmag[19:0];
            default: begin
              next_s.t_end = s.cmag[19:0];
              next_s.timed = 1'b1;
            end
          endcase
          idx = idx + 2'h1;
        end else if (s.last_prog == TIME_PROG && idx == 2'h1 &&
                     s.opt == OPT_REAL_TIME && s.prev_ent) begin
          next_s.rtl = 1'b1;
        end
        next_s.pidx = idx;
        next_s.cmag = 28'h0;
        next_s.cneg = 1'b0;
        next_s.cdp = 3'h0;
        next_s.cdig = 1'b0;
        next_s.cpt = 1'b0;
      end else if (c == CH_PLUS || c == CH_MINUS) begin
        next_s.cneg = c == CH_MINUS;
      end else if (c == CH_POINT) begin
        next_s.cpt = 1'b1;
      end else if (is_digit) begin
        next_s.cmag = 28'(s.cmag * 28'hA + 28'(c[3:0]));
        next_s.cdig = 1'b1;
        if (s.cpt) next_s.cdp = s.cdp + 3'h1;
      end else if (c == CH_ALARM || c == CH_REMOTE || c == CH_TALK ||
                   c == CH_SEQ) begin
        next_s.letter_v = 1'b1;
        next_s.letter = c;
      end else if (c == CH_GO) begin
        next_s.go_pend = 1'b1;
      end else if (c == CH_OPEN && s.st == ST_IDLE) begin
        next_s.st = ST_OPEN;
        next_s.ptr = 7'h0;
      end else if (c == CH_CR) begin
        next_s.pfresh = 1'b1;
        next_s.fwd_v = !late;
        next_s.fwd_ch = c;
        if (s.go_pend) begin
          next_s.go_pend = 1'b0;
          if (early) next_s.st = ST_WAIT;
          else next_s.go = !late;
        end else if (s.engaged && s.st == ST_IDLE && s.len != 8'h0) begin
          next_s.seq_act = 1'b1;
          next_s.ptr = 7'h0;
          next_s.st = early ? ST_WAIT : ST_RUN;
        end
      end else if (c >= CH_SP && c != CH_OPEN) begin
        next_s.fwd_v = 1'b1;
        next_s.fwd_ch = c;
      end
    end

    if (emit_v && s.remote && s.talk) begin
      next_s.tx_v = 1'b1;
      next_s.tx_ch = emit_ch;
    end

    // Read data is latched in setup so the access phase needs no wait state
    if (apb_req.psel && !apb_req.penable) begin
      next_s.pslverr = 1'b0;
      unique case (apb_req.paddr)
        A_CTRL: next_s.prdata = {31'h0, s.en};
        A_STATUS: next_s.prdata = {16'h0, s.len, s.proc_on, s.alarm,
                                   s.talk, s.remote, s.st};
        A_PROGS: next_s.prdata = {18'h0, s.pcnt, s.progs};
        A_CONST: next_s.prdata = {s.pnl.neg, s.pnl.dp, s.pnl.mag};
        A_START: next_s.prdata = {12'h0, s.t_start};
        A_INTVL: next_s.prdata = {12'h0, s.t_int};
        A_END: next_s.prdata = {12'h0, s.t_end};
        default: begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
        apb_req.paddr == A_CTRL) begin
      next_s.en = apb_req.pwdata[CTRL_EN_BIT];
      if (apb_req.pwdata[CTRL_ABORT_BIT]) begin
        next_s.st = ST_IDLE;
        next_s.seq_act = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.en <= CTRL_EN_RESET;
      s.pfresh <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // The store is not reset, so a listing after reset shows stale data
  always_ff @(posedge sys_clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign apb_rsp = '{prdata: s.prdata, pready: 1'b1, pslverr: s.pslverr};
  assign tx_valid = s.tx_v;
  assign tx_char = s.tx_ch;
  assign fwd_valid = s.fwd_v;
  assign fwd_char = s.fwd_ch;
  assign panel = s.pnl;
  assign meas_go = s.go;
  assign rt_load = s.rtl;
  assign remote_mode_on = s.remote;
  assign print_talk_setting = s.talk;
  assign alarm_print_on = s.alarm;
  assign processing_on = s.proc_on;
  assign prog_list = s.progs;
  assign alarm_filter = s.alarm && (s.progs[0] == LIMITS_PROG ||
    s.progs[1] == LIMITS_PROG || s.progs[2] == LIMITS_PROG);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic plain;
  assign plain = take && s.st == ST_IDLE && !s.dle && !s.letter_v;

  a_print_gate: assert property ($rose(tx_valid) |->
    $past(s.remote && s.talk)) else $error("print without remote talk");
  a_prog_cap: assert property (s.pcnt <= MAX_PROGS)
    else $error("more than three programs");
  a_prog_add: assert property (plain && s.exp_prog && is_digit &&
    s.pcnt == 2'h0 |=> s.proc_on && s.pcnt == 2'h1 &&
    s.progs[0] == $past(rx_char[3:0])) else $error("program not taken");
  a_exit_clear: assert property (plain && rx_char == CH_EXIT |=>
    !s.proc_on && s.pcnt == 2'h0 && panel.valid && panel.act == ACT_EXIT)
    else $error("exit did not clear");
  a_enter_act: assert property (plain && rx_char == CH_SEMI |=>
    panel.valid && panel.act == ACT_ENTER && panel.mag == $past(s.cmag)
    ##1 (!panel.valid || $past(take))) else $error("enter not one pulse");
  a_seq_cap: assert property (s.len <= SEQ_LEN_MAX)
    else $error("sequence over capacity");
  a_list_stop: assert property (take && s.st == ST_LIST &&
    rx_char == CH_SUB && mem_q == CH_CLOSE |=> s.st == ST_IDLE)
    else $error("listing did not stop at close");
  a_list_back: assert property (take && s.st == ST_LIST &&
    rx_char == CH_BS && s.ptr != 7'h0 |=> s.ptr == $past(s.ptr) - 7'h1)
    else $error("backspace did not step back");
  a_run_exit: assert property (take && s.st == ST_RUN |=>
    s.st == ST_IDLE) else $error("run not left on character");
  a_rt_load: assert property (rt_load |->
    $past(s.opt) == OPT_REAL_TIME && $past(s.pidx) == 2'h1)
    else $error("real time load out of place");
  a_wait_start: assert property (s.st == ST_WAIT && !take &&
    s.trl == 3'h0 && !early |=> meas_go && s.st != ST_WAIT)
    else $error("start time missed");
  a_trl_cr: assert property (s.trl == TRAILER_LEN && !s.tx_v &&
    s.remote && s.talk |=> tx_valid && tx_char == CH_CR ##0
    s.trl == 3'h5) else $error("trailer does not open with CR");

  c_list: cover property (s.st == ST_LIST ##1 s.st == ST_IDLE);
  c_run: cover property (s.st == ST_RUN ##1 s.st == ST_RUN);
  c_wait: cover property (s.st == ST_WAIT ##1 meas_go);
  c_rtl: cover property (rt_load);
endmodule : pmcp_parser

// >>> dv/pmcp_term.sv
`timescale 1ns/1ns
module pmcp_term (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Character stream from the device
  input wire logic tx_valid,
  output logic tx_ready,
  // Pace: a slow terminal accepts one cycle in four
  input wire logic slow
);
  logic [1:0] pace;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
    end
  end

  // Ready only while offered, so a stalled terminal never accepts early
  assign tx_ready = tx_valid && (!slow || pace == 2'h3);
endmodule : pmcp_term

// >>> dv/test_processed_measurement_command_parser.sv
`timescale 1ns/1ns
module test_processed_measurement_command_parser import pmcp_pkg::*; ;
  typedef struct packed {logic [6:0] c; pmcp_act_t a;} pmcp_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  pmcp_apb_req_t apb_req = '0;
  pmcp_apb_rsp_t apb_rsp;
  logic rx_valid = 1'b0;
  logic [6:0] rx_char = 7'h00;
  logic rx_ready, tx_valid, tx_ready, fwd_valid, meas_go, rt_load;
  logic [6:0] tx_char, fwd_char;
  logic [6:0] fwd_last = 7'h00;
  pmcp_panel_t panel;
  pmcp_time_t rtc_now = 20'h00000;
  logic msg_end = 1'b0;
  logic remote_mode_on, print_talk_setting, alarm_print_on, alarm_filter;
  logic processing_on, slow = 1'b0, e;
  logic [2:0][3:0] prog_list;
  logic [6:0] tx_log [0:127];
  logic [31:0] q;
  pmcp_act_t last_act;
  int tx_n = 0, go_n = 0, rtl_n = 0, pan_n = 0, cyc = 0, t0, n;
  int err_total = 0, checked = 0;
  pmcp_row_t rows [7] = '{'{CH_COMPUTE, ACT_COMPUTE},
    '{CH_RECALL, ACT_RECALL}, '{CH_CLEAR, ACT_CLEAR}, '{CH_SEMI, ACT_ENTER},
    '{CH_RBR, ACT_ENTER}, '{CH_LBR, ACT_ENTER}, '{CH_EXIT, ACT_EXIT}};

  pmcp_parser pmcp_parser_i (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_char(tx_char),
    .tx_ready(tx_ready), .fwd_valid(fwd_valid), .fwd_char(fwd_char),
    .panel(panel), .meas_go(meas_go), .rt_load(rt_load), .rtc_now(rtc_now),
    .msg_end(msg_end), .remote_mode_on(remote_mode_on),
    .print_talk_setting(print_talk_setting), .alarm_print_on(alarm_print_on),
    .alarm_filter(alarm_filter), .processing_on(processing_on),
    .prog_list(prog_list));
  pmcp_term pmcp_term_i (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .slow(slow));

  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Monitors catch one-cycle pulses so the sequence never has to hit them
  always @(posedge sys_clk) begin
    cyc++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_n < 128) begin
      tx_log[tx_n] = tx_char;
      tx_n++;
    end
    if (meas_go === 1'b1) go_n++;
    if (fwd_valid === 1'b1) fwd_last = fwd_char;
    if (rt_load === 1'b1) rtl_n++;
    if (panel.valid === 1'b1) begin
      pan_n++;
      last_act = panel.act;
    end
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_tx(input int b, input string s);
    int w;
    w = 0;
    while (tx_n < b + s.len() && w < 300) begin
      @(posedge sys_clk);
      w++;
    end
    for (int i = 0; i < s.len(); i++) begin
      chk({25'h0, tx_log[b + i]}, {24'h0, s[i]});
    end
  endtask : chk_tx

  // Idle cycle after each transfer keeps psel from being driven twice
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do @(posedge sys_clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge sys_clk);
  endtask : apb

  task automatic send(input logic [6:0] c);
    rx_valid <= 1'b1;
    rx_char <= c;
    do @(posedge sys_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : send

  task automatic sends(input string s);
    byte c;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      send(c[6:0]);
    end
    @(posedge sys_clk);
  endtask : sends

  task automatic end_msg();
    msg_end <= 1'b1;
    @(posedge sys_clk);
    msg_end <= 1'b0;
  endtask : end_msg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, A_STATUS, 32'h0);
    chk(q[7:0], 8'h00);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    end_msg();
    repeat (20) @(posedge sys_clk);
    chk(tx_n, 0);
    sends("L1T0A1");
    chk({remote_mode_on, print_talk_setting, alarm_print_on}, 3'h7);
    slow <= 1'b1;
    t0 = tx_n;
    end_msg();
    chk_tx(t0, "\r\n");
    while (tx_n < t0 + 6 && cyc < 2000) @(posedge sys_clk);
    for (int i = 2; i < 6; i++) chk(tx_log[t0 + i], 7'h00);
    slow <= 1'b0;
    foreach (rows[i]) begin
      n = pan_n;
      send(rows[i].c);
      @(posedge sys_clk);
      chk(pan_n, n + 1);
      chk(last_act, rows[i].a);
    end
    // Fourth program is beyond the three that may run together
    sends("P5#6#7#4");
    chk({processing_on, alarm_filter, prog_list}, {2'h3, 12'h765});
    apb(1'b0, A_PROGS, 32'h0);
    chk(q[13:0], {2'h3, 12'h765});
    sends("!");
    chk({processing_on, alarm_filter}, 2'h0);
    sends("-12.5;");
    apb(1'b0, A_CONST, 32'h0);
    chk({q[31], q[27:0]}, {1'b1, 28'd125});
    chk(q[30:28], 3'h1);
    apb(1'b1, A_CTRL, 32'h0);
    chk(rx_ready, 1'b0);
    apb(1'b1, A_CTRL, 32'h1);
    sends("%A");
    apb(1'b1, A_CTRL, 32'h3);
    apb(1'b0, A_STATUS, 32'h0);
    chk(q[3:0], 4'h0);
    sends("%A\020B$");
    apb(1'b0, A_STATUS, 32'h0);
    chk(q[15:8], 8'h04);
    t0 = tx_n;
    sends("%\032\032\032\032");
    chk_tx(t0, "A\020B$");
    apb(1'b0, A_STATUS, 32'h0);
    chk(q[3:0], 4'h0);
    t0 = tx_n;
    sends("%\032\032\010C\033");
    chk_tx(t0, "A\020\010");
    t0 = tx_n;
    sends("%\032\032\032\032");
    chk_tx(t0, "ACB$");
    sends("P9[1;;5;1;9]");
    chk(rtl_n, 1);
    apb(1'b0, A_START, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, A_END, 32'h0);
    chk(q, 32'h9);
    n = go_n;
    sends("G\r");
    apb(1'b0, A_STATUS, 32'h0);
    chk(go_n, n);
    chk(q[3:0], 4'h5);
    chk(fwd_last, CH_CR);
    rtc_now <= 20'h00005;
    repeat (4) @(posedge sys_clk);
    chk(go_n, n + 1);
    sends("!");
    chk(processing_on, 1'b0);
    // Title char after DLE and a device-control char must both reach tx
    sends("%\020Q\021$");
    t0 = tx_n;
    sends("X1\r");
    chk_tx(t0, "\020Q\021\020Q\021");
    sends("Z");
    apb(1'b0, A_STATUS, 32'h0);
    chk(q[3:0], 4'h0);
    complete_run();
  end
endmodule : test_processed_measurement_command_parser
